// ---- esimpc_far_model.sv ----
module esimpc_far_model
   import esimpc_pkg::*;
(
   // Clock.
   input wire logic sys_clk,
   // Source encoder, drive position and freeze line.
   output esim_enc_type enc_in,
   output logic [15:0] main_rev,
   output logic [15:0] main_pos,
   output logic feedback_valid,
   output logic freeze_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_q = 2'h0;

   // All lines start quiet so no marker or freeze is captured before the bench asks.
   initial begin
      enc_in = '0;
      main_rev = 16'h0000;
      main_pos = 16'h0000;
      feedback_valid = 1'b0;
      freeze_in = 1'b0;
      repeat (60) @(posedge sys_clk);
      feedback_valid <= 1'b1;
      repeat (400) @(posedge sys_clk);
      feedback_valid <= 1'b0;
   end

   // Source turns in reverse on a power-of-two line count, so marker lock is fair.
   always @(posedge sys_clk) begin
      ph_q <= ph_q + 2'h1;
      enc_in.a <= ph_q[1];
      enc_in.b <= ph_q[1] ^ ph_q[0];
   end

   // Drive position as the main counter would show it.
   task automatic set_main(input logic [15:0] r, input logic [15:0] p);
      main_rev <= r;
      main_pos <= p;
   endtask

   // Eight-cycle pulse on the marker or the freeze line; long enough for the synchroniser.
   task automatic pulse(input bit mk);
      if (mk) begin
         enc_in.z <= 1'b1;
      end else begin
         freeze_in <= 1'b1;
      end
      repeat (8) @(posedge sys_clk);
      enc_in.z <= 1'b0;
      freeze_in <= 1'b0;
   endtask
endmodule

// ---- esimpc_pkg.sv ----
package esimpc_pkg;
   // Register byte addresses on the Avalon-MM slave.
   localparam logic [5:0] REG_FORMAT = 6'h00;
   localparam logic [5:0] REG_RAW_REV = 6'h04;
   localparam logic [5:0] REG_RAW_POS = 6'h08;
   localparam logic [5:0] REG_MRK_REV = 6'h0C;
   localparam logic [5:0] REG_MRK_POS = 6'h10;
   localparam logic [5:0] REG_FRZ_REV = 6'h14;
   localparam logic [5:0] REG_FRZ_POS = 6'h18;
   localparam logic [5:0] REG_FRZ_FLAG = 6'h1C;
   localparam logic [5:0] REG_INIT = 6'h20;
   localparam logic [5:0] REG_LOCK = 6'h24;
   localparam logic [5:0] REG_ERROR = 6'h28;
   localparam logic [5:0] REG_RATIO = 6'h2C;
   localparam logic [5:0] REG_IRQ_STAT = 6'h30;
   localparam logic [5:0] REG_IRQ_MASK = 6'h34;
   // Interrupt status bit positions.
   localparam int IRQ_MARKER = 0;
   localparam int IRQ_FREEZE = 1;
   localparam int IRQ_ERROR = 2;
   localparam int IRQ_FAN = 3;
   localparam int IRQ_W = 4;
   // Error codes and thermal thresholds in degrees C.
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_OVERTEMP = 8'd74;
   localparam logic [7:0] TEMP_FAN_C = 8'd90;
   localparam logic [7:0] TEMP_TRIP_C = 8'd100;
   // Timing.
   localparam int CLK_HZ = 100_000_000;
   localparam int UPDATE_MS = 4;
   localparam int FAN_MIN_S = 10;
   localparam int UPDATE_CYC = CLK_HZ / 1000 * UPDATE_MS;
   localparam longint FAN_MIN_CYC = longint'(CLK_HZ) * FAN_MIN_S;
   // Ratio codes: 0 = 1/32 ... 4 = 1/2, 5 = 1.
   localparam logic [2:0] RATIO_ONE = 3'h5;
   localparam logic [2:0] FMT_QUAD = 3'h0;
   localparam logic [2:0] FMT_FDIR = 3'h1;
   localparam logic [2:0] FMT_FWDREV = 3'h2;
   localparam logic [2:0] FMT_QUAD_LOCK = 3'h3;

   typedef enum logic [1:0] {ESIM_QUAD, ESIM_FDIR, ESIM_FWDREV} esim_mode_type;

   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } esim_enc_type;

   typedef struct packed {
      logic [2:0] format;
      logic [2:0] ratio;
      logic [15:0] raw_rev;
      logic [15:0] raw_pos;
      logic [15:0] mrk_rev;
      logic [15:0] mrk_pos;
      logic [15:0] frz_rev;
      logic [15:0] frz_pos;
      logic frz_flag;
      logic frz_pend;
      logic init;
      logic lock;
      logic [7:0] err;
      logic trip;
      logic fan;
      logic [31:0] fan_cnt;
      logic [31:0] upd_cnt;
      logic [2:0] in_sy1;
      logic [2:0] in_sy2;
      logic [2:0] in_last;
      logic frz_sy1;
      logic frz_sy2;
      logic frz_last;
      logic [20:0] sim_pos;
      logic marker_seen;
      esim_enc_type out;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic [31:0] rdata;
      logic rvalid;
   } esim_state_type;
endpackage

// ---- esimpc_top.sv ----
// Contract
// - Decode format: quad, freq/dir, fwd/rev, locked variants.
// - Marker output follows source marker, width unchanged.
// - Marker lock aligns position at first marker.
// - Raw counts mirror main counter, untouched by events.
// - Marker edge captures raw counts.
// - Freeze comes from outside; evaluated each period.
// - Freeze with flag clear stores data, sets flag.
// - Initialised flag rises once, then stays.
// - Lock bit holds main counts frozen.
// - Nonzero error code, request slot error trip.
// - Drive reset clears error status.
// - Above 90C fan forced, at least 10s.
// - Above 100C trip and error 74.
// - Ratio setting selects divide 1/32 up to 1.
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
module esimpc_top
   import esimpc_pkg::*;
#(
   parameter int NUM_MODULES = 1,
   parameter int UPDATE_CYCLES = UPDATE_CYC,
   parameter longint FAN_HOLD_CYCLES = FAN_MIN_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Avalon-MM slave.
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Encoder source pins and main position from the drive.
   input wire esim_enc_type enc_in,
   input wire logic [15:0] main_rev,
   input wire logic [15:0] main_pos,
   input wire logic feedback_valid,
   input wire logic freeze_in,
   input wire logic drive_reset,
   input wire logic [7:0] board_temp_c,
   // Simulation output, thermal and trip outputs.
   output esim_enc_type sim_out,
   output logic fan_force,
   output logic slot_error_trip,
   output logic irq
);
   initial begin
      if (NUM_MODULES < 1 || NUM_MODULES > 8 || UPDATE_CYCLES < 1 || FAN_HOLD_CYCLES < 1) begin
         $error("esimpc_top: unsupported parameter values");
      end
   end

   localparam logic [31:0] PERIOD = 32'(UPDATE_CYCLES * NUM_MODULES);
   localparam logic [31:0] FAN_HOLD = 32'(FAN_HOLD_CYCLES);

   esim_state_type s_q, s_d;
   logic period_tick, mark_rise, frz_rise, src_step, src_dir, hot, over;
   logic [20:0] step_sz;
   logic [IRQ_W-1:0] ev;

   // Pin level inputs; the first stage is read only by the second stage.
   assign period_tick = (s_q.upd_cnt == PERIOD - 32'h1);
   assign mark_rise = s_q.in_sy2[0] & ~s_q.in_last[0];
   assign frz_rise = s_q.frz_sy2 & ~s_q.frz_last;
   assign hot = board_temp_c > TEMP_FAN_C;
   assign over = board_temp_c > TEMP_TRIP_C;

   // Source direction from a quadrature pair: step on any A edge.
   assign src_step = s_q.in_sy2[2] ^ s_q.in_last[2];
   assign src_dir = s_q.in_sy2[2] ^ s_q.in_sy2[1];

   // Divide ratio: the simulated position advances 2^ratio per source edge out of 2^5.
   assign step_sz = 21'h1 << s_q.ratio;

   always_comb begin
      esim_mode_type mode;
      logic lockmode;
      logic [4:0] ph;
      s_d = s_q;
      mode = ESIM_QUAD;
      lockmode = 1'b0;
      ph = 5'h00;
      ev = '0;
      s_d.rvalid = 1'b0;
      s_d.in_sy1 = {enc_in.a, enc_in.b, enc_in.z};
      s_d.in_sy2 = s_q.in_sy1;
      s_d.in_last = s_q.in_sy2;
      s_d.frz_sy1 = freeze_in;
      s_d.frz_sy2 = s_q.frz_sy1;
      s_d.frz_last = s_q.frz_sy2;
      s_d.upd_cnt = period_tick ? 32'h0 : s_q.upd_cnt + 32'h1;

      // Output format decode.
      case (s_q.format)
         FMT_QUAD: mode = ESIM_QUAD;
         FMT_FDIR: mode = ESIM_FDIR;
         FMT_FWDREV: mode = ESIM_FWDREV;
         FMT_QUAD_LOCK: begin
            mode = ESIM_QUAD;
            lockmode = 1'b1;
         end
         default: begin
            mode = ESIM_FDIR;
            lockmode = 1'b1;
         end
      endcase

      // Simulated incremental position and marker lock alignment.
      if (src_step) begin
         s_d.sim_pos = src_dir ? s_q.sim_pos + step_sz : s_q.sim_pos - step_sz;
      end
      if (lockmode && mark_rise && !s_q.marker_seen) begin
         // Phase 3 of the quadrature cycle has A and B both high.
         s_d.sim_pos = {s_q.sim_pos[20:7], 2'b11, 5'h00};
         s_d.marker_seen = 1'b1;
      end
      // Outputs follow the new position, so the aligned phase leaves with the marker itself.
      ph = s_d.sim_pos[9:5];
      case (mode)
         ESIM_QUAD: begin
            s_d.out.a = ph[1];
            s_d.out.b = ph[1] ^ ~ph[0];
         end
         ESIM_FDIR: begin
            s_d.out.a = ph[0];
            s_d.out.b = src_dir;
         end
         default: begin
            s_d.out.a = ph[0] & src_dir;
            s_d.out.b = ph[0] & ~src_dir;
         end
      endcase
      s_d.out.z = s_q.in_sy2[0];

      // Position counts follow the main counter once per period.
      if (period_tick && !s_q.lock) begin
         s_d.raw_rev = main_rev;
         s_d.raw_pos = main_pos;
      end
      if (mark_rise) begin
         s_d.mrk_rev = s_q.raw_rev;
         s_d.mrk_pos = s_q.raw_pos;
         ev[IRQ_MARKER] = 1'b1;
      end
      if (frz_rise) begin
         s_d.frz_pend = 1'b1;
      end
      if (period_tick && s_q.frz_pend) begin
         s_d.frz_pend = frz_rise;
         if (!s_q.frz_flag) begin
            s_d.frz_rev = s_q.raw_rev;
            s_d.frz_pos = s_q.raw_pos;
            s_d.frz_flag = 1'b1;
            ev[IRQ_FREEZE] = 1'b1;
         end
      end
      if (period_tick && feedback_valid) begin
         s_d.init = 1'b1;
      end

      // Thermal supervision.
      if (hot) begin
         s_d.fan = 1'b1;
         s_d.fan_cnt = FAN_HOLD;
         ev[IRQ_FAN] = ~s_q.fan;
      end else if (s_q.fan_cnt != 32'h0) begin
         s_d.fan_cnt = s_q.fan_cnt - 32'h1;
      end else begin
         s_d.fan = 1'b0;
      end
      if (drive_reset) begin
         s_d.err = ERR_NONE;
         s_d.trip = 1'b0;
      end
      if (over) begin
         s_d.err = ERR_OVERTEMP;
         s_d.trip = 1'b1;
         ev[IRQ_ERROR] = (s_q.err != ERR_OVERTEMP);
      end

      // Register bus: a write takes effect in the cycle it is seen; a read answers one cycle later.
      if (write) begin
         case (address)
            REG_FORMAT: s_d.format = writedata[2:0];
            REG_RATIO: s_d.ratio = (writedata[2:0] > RATIO_ONE) ? RATIO_ONE : writedata[2:0];
            REG_LOCK: s_d.lock = writedata[0];
            REG_FRZ_FLAG: begin
               // A capture in this same cycle keeps the flag set.
               if (!writedata[0] && !ev[IRQ_FREEZE]) begin
                  s_d.frz_flag = 1'b0;
               end
            end
            REG_IRQ_MASK: s_d.irq_mask = writedata[IRQ_W-1:0];
            REG_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~writedata[IRQ_W-1:0];
            default: s_d.format = s_d.format;
         endcase
      end
      s_d.irq_stat = s_d.irq_stat | ev;
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

      s_d.rdata = 32'h0;
      if (read) begin
         s_d.rvalid = 1'b1;
         case (address)
            REG_FORMAT: s_d.rdata = {29'h0, s_q.format};
            REG_RAW_REV: s_d.rdata = {16'h0, s_q.raw_rev};
            REG_RAW_POS: s_d.rdata = {16'h0, s_q.raw_pos};
            REG_MRK_REV: s_d.rdata = {16'h0, s_q.mrk_rev};
            REG_MRK_POS: s_d.rdata = {16'h0, s_q.mrk_pos};
            REG_FRZ_REV: s_d.rdata = {16'h0, s_q.frz_rev};
            REG_FRZ_POS: s_d.rdata = {16'h0, s_q.frz_pos};
            REG_FRZ_FLAG: s_d.rdata = {31'h0, s_q.frz_flag};
            REG_INIT: s_d.rdata = {31'h0, s_q.init};
            REG_LOCK: s_d.rdata = {31'h0, s_q.lock};
            REG_ERROR: s_d.rdata = {24'h0, s_q.err};
            REG_RATIO: s_d.rdata = {29'h0, s_q.ratio};
            REG_IRQ_STAT: s_d.rdata = {28'h0, s_q.irq_stat};
            REG_IRQ_MASK: s_d.rdata = {28'h0, s_q.irq_mask};
            default: s_d.rdata = 32'h0;
         endcase
      end
   end

   // Single state register; a read holds off one cycle so data comes from a flip-flop.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.ratio <= RATIO_ONE;
      end else begin
         s_q <= s_d;
      end
   end

   assign readdata = s_q.rdata;
   assign waitrequest = read & ~s_q.rvalid;
   assign sim_out = s_q.out;
   assign fan_force = s_q.fan;
   assign slot_error_trip = s_q.trip;
   assign irq = s_q.irq;

   // Assertions.
   a_marker_capture: assert property (@(posedge sys_clk) disable iff (!reset_n)
      mark_rise |=> (s_q.mrk_rev == $past(s_q.raw_rev))) else $error("marker capture wrong");
   a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_q.frz_flag |=> $stable(s_q.frz_rev)) else $error("freeze overwritten");
   a_freeze_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (period_tick && s_q.frz_pend && !s_q.frz_flag) |=> s_q.frz_flag) else $error("freeze not stored");
   a_init_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_q.init |=> s_q.init) else $error("init flag dropped");
   a_lock_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_q.lock && !write |=> $stable(s_q.raw_rev)) else $error("locked count moved");
   a_overtemp_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
      over |=> (s_q.err == ERR_OVERTEMP) && slot_error_trip) else $error("no overtemp trip");
   a_fan_force: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hot |=> fan_force [*8]) else $error("fan not held");
   a_reset_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
      drive_reset && !over |=> s_q.err == ERR_NONE) else $error("error not cleared");
   a_marker_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
      1'b1 |=> sim_out.z == $past(s_q.in_sy2[0])) else $error("marker not passed");
   c_marker: cover property (@(posedge sys_clk) disable iff (!reset_n) mark_rise);
   c_freeze: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(s_q.frz_flag));
   c_trip: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(slot_error_trip));

   // The first marker in quadrature lock leaves with A and B both high.
   a_quad_align: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (mark_rise && s_q.format == FMT_QUAD_LOCK && !s_q.marker_seen) |=> sim_out.a && sim_out.b)
      else $error("quadrature marker not aligned");

   // The first marker in frequency lock leaves with the frequency line high.
   a_fdir_align: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (mark_rise && s_q.format[2] && !s_q.marker_seen) |=> sim_out.a)
      else $error("frequency marker not aligned");

   // Alignment happens once; later markers must not shift the position again.
   a_lock_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_q.marker_seen |=> s_q.marker_seen)
      else $error("marker lock state dropped");

   // Forward and reverse lines never pulse together.
   a_fwdrev_excl: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (s_q.format == FMT_FWDREV) |=> !(sim_out.a && sim_out.b))
      else $error("forward and reverse both high");

   // In frequency form the second line carries the direction.
   a_fdir_dir: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (s_q.format == FMT_FDIR) |=> sim_out.b == $past(src_dir))
      else $error("direction line wrong");

   // Unlocked counts take the main counter at each period tick.
   a_raw_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (period_tick && !s_q.lock) |=> s_q.raw_rev == $past(main_rev) && s_q.raw_pos == $past(main_pos))
      else $error("raw counts not refreshed");

   // Between ticks nothing, marker and freeze included, moves the raw counts.
   a_raw_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !period_tick |=> $stable(s_q.raw_rev) && $stable(s_q.raw_pos))
      else $error("raw counts disturbed");

   // The marker position capture takes the raw position.
   a_marker_pos: assert property (@(posedge sys_clk) disable iff (!reset_n)
      mark_rise |=> s_q.mrk_pos == $past(s_q.raw_pos))
      else $error("marker position capture wrong");

   // Without a marker edge the captures stay put.
   a_marker_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !mark_rise |=> $stable(s_q.mrk_rev) && $stable(s_q.mrk_pos))
      else $error("marker capture moved");

   // Freeze data is only evaluated at the period tick.
   a_freeze_tick: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !period_tick |=> $stable(s_q.frz_rev) && $stable(s_q.frz_pos))
      else $error("freeze stored off tick");

   // Only a software write may lower the freeze flag.
   a_freeze_keep: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (s_q.frz_flag && !(write && address == REG_FRZ_FLAG)) |=> s_q.frz_flag)
      else $error("freeze flag lost");

   // The frozen position stays while the flag is set.
   a_freeze_pos: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_q.frz_flag |=> $stable(s_q.frz_pos))
      else $error("freeze position overwritten");

   // The initialised flag rises only on valid feedback at a tick.
   a_init_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!s_q.init && !(period_tick && feedback_valid)) |=> !s_q.init)
      else $error("init flag rose early");

   // A trip always comes with a nonzero reason code.
   a_err_trip: assert property (@(posedge sys_clk) disable iff (!reset_n)
      slot_error_trip |-> s_q.err != ERR_NONE)
      else $error("trip without error code");

   // A trip stays until the drive is reset.
   a_trip_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (slot_error_trip && !drive_reset) |=> slot_error_trip)
      else $error("trip dropped");

   // Only a drive reset or an overtemperature changes the error code.
   a_err_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!drive_reset && !over) |=> $stable(s_q.err))
      else $error("error code changed");

   // Fan is released once cool and the hold has run out.
   a_fan_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!hot && s_q.fan_cnt == 32'h0) |=> !fan_force)
      else $error("fan not released");

   // Fan stays forced while the hold count runs.
   a_fan_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (s_q.fan && s_q.fan_cnt != 32'h0) |=> fan_force)
      else $error("fan released early");

   // The ratio code never leaves the decoded range.
   a_ratio_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_q.ratio <= RATIO_ONE)
      else $error("ratio code out of range");

   // Writes are taken without wait states.
   a_write_nowait: assert property (@(posedge sys_clk) disable iff (!reset_n)
      write |-> !waitrequest)
      else $error("write stalled");

   // Read data returns to zero when no read is in flight.
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !read |=> readdata == 32'h0)
      else $error("stale read data");

   // An event sets its status bit even when a clear hits the same cycle.
   a_irq_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (|ev) |=> (s_q.irq_stat & $past(ev)) == $past(ev))
      else $error("event status lost");

   c_lock_align: cover property (@(posedge sys_clk) disable iff (!reset_n)
      mark_rise && s_q.format == FMT_QUAD_LOCK);
   c_fan: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(fan_force));
endmodule

// ---- esimpc_top_tb.sv ----
module esimpc_top_tb
   import esimpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset_n, read, write, drive_reset, waitrequest;
   logic [5:0] address;
   logic [31:0] writedata, readdata;
   esim_enc_type enc_in, sim_out;
   logic [15:0] main_rev, main_pos, rv, pv;
   logic feedback_valid, freeze_in, fan_force, slot_error_trip, irq, i0;
   logic [7:0] board_temp_c;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int checks_done = 0;
   int n;

   // Short period and fan hold keep the run brief.
   esimpc_top #(.UPDATE_CYCLES(16), .FAN_HOLD_CYCLES(20)) i_dut (.sys_clk(sys_clk),
      .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .enc_in(enc_in), .main_rev(main_rev), .main_pos(main_pos),
      .feedback_valid(feedback_valid), .freeze_in(freeze_in), .drive_reset(drive_reset),
      .board_temp_c(board_temp_c), .sim_out(sim_out), .fan_force(fan_force),
      .slot_error_trip(slot_error_trip), .irq(irq));
   esimpc_far_model i_far (.sys_clk(sys_clk), .enc_in(enc_in), .main_rev(main_rev),
      .main_pos(main_pos), .feedback_valid(feedback_valid), .freeze_in(freeze_in));

   // Free-running 100 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Requests are held until waitrequest is seen low; a pause keeps strobes apart.
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      @(negedge sys_clk);
      while (waitrequest !== 1'b0) @(negedge sys_clk);
      @(posedge sys_clk);
      write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      address <= a;
      read <= 1'b1;
      @(negedge sys_clk);
      while (waitrequest !== 1'b0) @(negedge sys_clk);
      @(posedge sys_clk);
      read <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Read data is judged at the edge that takes it, against the oldest note.
   always @(posedge sys_clk) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         chk(readdata, exp_q.pop_front());
      end
   end

   // A hang is cut short well beyond the under a thousand cycles the tests need.
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      give_verdict();
   end

   initial begin
      reset_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      writedata = 32'h0;
      drive_reset = 1'b0;
      void'($urandom(47));
      board_temp_c = 8'(8'h10 + 8'($urandom % 64));
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(REG_FORMAT, 32'h0);
      rd(REG_RATIO, 32'h5);
      rd(REG_FRZ_FLAG, 32'h0);
      rd(REG_INIT, 32'h0);
      rd(REG_ERROR, 32'h0);
      rd(6'h3C, 32'h0);
      for (int f = 0; f < 8; f++) begin
         wr(REG_FORMAT, 32'(f));
         rd(REG_FORMAT, 32'(f));
      end
      wr(REG_RATIO, 32'h7);
      rd(REG_RATIO, 32'h5);
      wr(REG_RATIO, 32'h5);
      wr(REG_FORMAT, 32'h3);
      // Raw counts follow the drive, and the lock holds them.
      rv = 16'($urandom);
      pv = 16'($urandom);
      i_far.set_main(rv, pv);
      repeat (40) @(posedge sys_clk);
      rd(REG_RAW_REV, {16'h0, rv});
      wr(REG_LOCK, 32'h1);
      i_far.set_main(~rv, ~pv);
      repeat (40) @(posedge sys_clk);
      rd(REG_RAW_POS, {16'h0, pv});
      wr(REG_LOCK, 32'h0);
      repeat (40) @(posedge sys_clk);
      rd(REG_RAW_POS, {16'h0, ~pv});
      // First marker in lock mode lands on A and B high, at the input's width.
      fork
         i_far.pulse(1'b1);
         begin
            n = 0;
            while (sim_out.z !== 1'b1 && n < 20) begin
               @(negedge sys_clk);
               n++;
            end
            chk({30'h0, sim_out.a, sim_out.b}, 32'h3);
            n = 0;
            while (sim_out.z === 1'b1 && n < 20) begin
               @(negedge sys_clk);
               n++;
            end
            chk(32'(n), 32'h8);
         end
      join
      rd(REG_MRK_REV, {16'h0, ~rv});
      rd(REG_MRK_POS, {16'h0, ~pv});
      rd(REG_RAW_REV, {16'h0, ~rv});
      // A second freeze is dropped while the flag is set; software must clear the flag.
      i_far.pulse(1'b0);
      repeat (40) @(posedge sys_clk);
      rd(REG_FRZ_FLAG, 32'h1);
      rd(REG_FRZ_REV, {16'h0, ~rv});
      i_far.set_main(rv, pv);
      repeat (40) @(posedge sys_clk);
      i_far.pulse(1'b0);
      repeat (40) @(posedge sys_clk);
      rd(REG_FRZ_POS, {16'h0, ~pv});
      wr(REG_FRZ_FLAG, 32'h0);
      i_far.pulse(1'b0);
      repeat (40) @(posedge sys_clk);
      rd(REG_FRZ_POS, {16'h0, pv});
      // Marker and freeze events are pending; the mask must change the line.
      rd(REG_IRQ_STAT, 32'h3);
      wr(REG_IRQ_MASK, 32'h0);
      i0 = irq;
      wr(REG_IRQ_MASK, 32'hF);
      chk(32'(i0 ^ irq), 32'h1);
      wr(REG_IRQ_STAT, 32'hF);
      rd(REG_IRQ_STAT, 32'h0);
      chk(32'(irq), 32'h0);
      // Warm board forces the fan and keeps it on for the hold after cooling.
      board_temp_c <= 8'h5F;
      repeat (5) @(posedge sys_clk);
      chk(32'(fan_force), 32'h1);
      board_temp_c <= 8'h50;
      repeat (10) @(posedge sys_clk);
      chk(32'(fan_force), 32'h1);
      repeat (30) @(posedge sys_clk);
      chk(32'(fan_force), 32'h0);
      board_temp_c <= 8'h69;
      repeat (5) @(posedge sys_clk);
      chk(32'(slot_error_trip), 32'h1);
      rd(REG_ERROR, 32'h4A);
      board_temp_c <= 8'h19;
      drive_reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      drive_reset <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(REG_ERROR, 32'h0);
      rd(REG_INIT, 32'h1);
      give_verdict();
   end
endmodule
